//--- hdl/dcsw_pkg.sv
package dcsw_pkg;
  // Functional notes
  // - Command bits 0..3 pick one of sixteen fixed setpoints.
  // - Command bits 4..5 pick the motor parameter set.
  // - Command bit 11 high enables speed controller droop, low inhibits it.
  // - Command bit 12 high selects torque control, low speed control.
  // - Command bit 13 low raises the external fault.
  // - Command bit 15 is bit one of the command parameter set.
  // - Command and status bit placement are defaults, remappable by configuration.
  // - Leaving telegram 350 for any telegram but the free one clears command connections, external fault input forced high.
  // - Status bit 1 set while speed magnitude exceeds standstill threshold.
  // - Status bit 2 set while speed magnitude exceeds minimum speed.
  // - Status bit 3 set while current is at or above its threshold.
  // - Status bit 4 set while speed magnitude exceeds second speed threshold.
  // - Status bit 5 set while speed magnitude is at or below it.
  // - Status bit 7 set while DC link voltage is at or below threshold.
  // - Status bit 8 set while DC link voltage is above that threshold.
  // - Status bit 9 set while the setpoint ramp generator is idle.
  // - Status bit 10 set while controller output is at or below lower limit.
  // - Status bit 11 set while controller output exceeds upper limit.
  // - Any telegram but the free one fixes its connections; remap writes are rejected.

  localparam logic [9:0]  TELEGRAM_350  = 10'h15e;
  localparam logic [9:0]  TELEGRAM_FREE = 10'h3e7;

  localparam int CMD_FSP_LSB      = 0;
  localparam int CMD_MPS_LSB      = 4;
  localparam int CMD_TECH_EN      = 8;
  localparam int CMD_DCB_EN       = 9;
  localparam int CMD_DROOP        = 11;
  localparam int CMD_TORQUE       = 12;
  localparam int CMD_NO_EXT_FAULT = 13;
  localparam int CMD_CPS_BIT1     = 15;

  localparam int ST_DCB_ACTIVE = 0;
  localparam int ST_STANDSTILL = 1;
  localparam int ST_MIN_SPEED  = 2;
  localparam int ST_CURRENT    = 3;
  localparam int ST_SPD2_ABOVE = 4;
  localparam int ST_SPD2_BELOW = 5;
  localparam int ST_SP_REACHED = 6;
  localparam int ST_VDC_LOW    = 7;
  localparam int ST_VDC_HIGH   = 8;
  localparam int ST_RAMP_DONE  = 9;
  localparam int ST_TECH_LOW   = 10;
  localparam int ST_TECH_HIGH  = 11;

  localparam logic [15:0] CMD_RESET     = 16'h2000;
  localparam logic [15:0] FUNC_FORCED   = 16'h2000;
  localparam logic [15:0] STATE_RESET   = 16'h0000;
  localparam logic [11:0] CTRL_RESET    = 12'h000;

  typedef logic [3:0] dcsw_sel_t;

  typedef struct packed {
    logic signed [15:0] speed_act;
    logic [15:0]        current_act;
    logic [15:0]        dc_link;
    logic signed [15:0] tech_out;
    logic               dc_brake_active;
    logic               setpoint_reached;
    logic               ramp_active;
  } dcsw_meas_t;

  typedef struct packed {
    logic [15:0]        standstill_thr;
    logic [15:0]        min_speed;
    logic [15:0]        current_thr;
    logic [15:0]        speed_thr2;
    logic [15:0]        dc_link_thr;
    logic signed [15:0] tech_lower;
    logic signed [15:0] tech_upper;
  } dcsw_limits_t;

  typedef struct packed {
    logic [3:0] fixed_setpoint_sel;
    logic [1:0] motor_parameter_set;
    logic       tech_ctrl_enable;
    logic       dc_brake_enable;
    logic       droop_enable;
    logic       torque_mode;
    logic       ext_fault;
    logic       command_parameter_set_bit1;
  } dcsw_ctrl_t;
endpackage

//--- hdl/dcsw_top.sv
`timescale 1ns/1ps
module dcsw_top
  import dcsw_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Telegram selection
  input  wire logic [9:0]   telegram_sel,
  // Received process data word
  input  wire logic         cmd_strobe,
  input  wire logic [15:0]  cmd_word_in,
  // Drive internal signals
  input  wire dcsw_meas_t   meas,
  input  wire dcsw_limits_t limits,
  // Connection configuration
  input  wire logic         map_wr,
  input  wire logic         map_is_status,
  input  wire dcsw_sel_t    map_idx,
  input  wire dcsw_sel_t    map_src,
  // Word registers
  output logic [15:0]       drive_command_word_three,
  output logic [15:0]       drive_state_word_three,
  // Decoded drive functions
  output dcsw_ctrl_t        ctrl,
  // Configuration answer
  output logic              map_accept,
  output logic              map_reject
);

  logic [15:0][3:0] cmd_map;
  logic [15:0][3:0] stat_map;
  logic [15:0]      mapped_cmd;
  logic [15:0]      mapped_stat;
  logic [15:0]      status_src;
  logic [15:0]      next_func;
  logic [15:0]      next_state;
  dcsw_ctrl_t       next_ctrl;
  logic [15:0]      speed_mag;
  logic [15:0]      neg_speed;
  wire              sel_350;
  wire              free_mode;
  wire              link_on;
  wire              map_ok;
  wire              map_bad;

  // Telegram decode
  assign sel_350   = (telegram_sel == TELEGRAM_350);
  assign free_mode = (telegram_sel == TELEGRAM_FREE);
  assign link_on   = sel_350 | free_mode;
  assign map_ok    = map_wr & free_mode;
  assign map_bad   = map_wr & ~free_mode;

  // Speed magnitude
  assign neg_speed = 16'(-meas.speed_act);
  assign speed_mag = meas.speed_act[15] ? neg_speed : meas.speed_act;

  // Status sources in default order
  assign status_src[ST_DCB_ACTIVE] = meas.dc_brake_active;
  assign status_src[ST_STANDSTILL] = speed_mag > limits.standstill_thr;
  assign status_src[ST_MIN_SPEED]  = speed_mag > limits.min_speed;
  assign status_src[ST_CURRENT]    = meas.current_act >= limits.current_thr;
  assign status_src[ST_SPD2_ABOVE] = speed_mag > limits.speed_thr2;
  assign status_src[ST_SPD2_BELOW] = speed_mag <= limits.speed_thr2;
  assign status_src[ST_SP_REACHED] = meas.setpoint_reached;
  assign status_src[ST_VDC_LOW]    = meas.dc_link <= limits.dc_link_thr;
  assign status_src[ST_VDC_HIGH]   = meas.dc_link > limits.dc_link_thr;
  assign status_src[ST_RAMP_DONE]  = ~meas.ramp_active;
  assign status_src[ST_TECH_LOW]   = meas.tech_out <= limits.tech_lower;
  assign status_src[ST_TECH_HIGH]  = meas.tech_out > limits.tech_upper;
  assign status_src[15:12]         = 4'h0;

  // Per bit connection select
  for (genvar g = 0; g < 16; g++) begin : g_conn
    assign mapped_cmd[g]  = free_mode ? cmd_q_bit(cmd_map[g])
                                      : drive_command_word_three[g];
    assign mapped_stat[g] = free_mode ? status_src[stat_map[g]] : status_src[g];
  end

  function automatic logic cmd_q_bit(input logic [3:0] idx);
    cmd_q_bit = drive_command_word_three[idx];
  endfunction

  // Forced value outside the telegram
  assign next_func  = link_on ? mapped_cmd : FUNC_FORCED;
  assign next_state = mapped_stat;

  // Function decode
  assign next_ctrl.fixed_setpoint_sel  = next_func[CMD_FSP_LSB +: 4];
  assign next_ctrl.motor_parameter_set = next_func[CMD_MPS_LSB +: 2];
  assign next_ctrl.tech_ctrl_enable    = next_func[CMD_TECH_EN];
  assign next_ctrl.dc_brake_enable     = next_func[CMD_DCB_EN];
  assign next_ctrl.droop_enable        = next_func[CMD_DROOP];
  assign next_ctrl.torque_mode         = next_func[CMD_TORQUE];
  assign next_ctrl.ext_fault           = ~next_func[CMD_NO_EXT_FAULT];
  assign next_ctrl.command_parameter_set_bit1 = next_func[CMD_CPS_BIT1];

  // Command word store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drive_command_word_three <= CMD_RESET;
    end else if (cmd_strobe) begin
      drive_command_word_three <= cmd_word_in;
    end
  end

  // Decoded outputs and status word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl                   <= CTRL_RESET;
      drive_state_word_three <= STATE_RESET;
    end else begin
      ctrl                   <= next_ctrl;
      drive_state_word_three <= next_state;
    end
  end

  // Connection tables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        cmd_map[i]  <= 4'(i);
        stat_map[i] <= 4'(i);
      end
    end else if (map_ok && map_is_status) begin
      stat_map[map_idx] <= map_src;
    end else if (map_ok) begin
      cmd_map[map_idx] <= map_src;
    end
  end

  // Configuration answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      map_accept <= 1'b0;
      map_reject <= 1'b0;
    end else begin
      map_accept <= map_ok;
      map_reject <= map_bad;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [15:0] spd_mag_d;
  logic        past_350;
  logic        past_free;

  // History for checks; status checks muted for one edge after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      past_350  <= 1'b0;
      past_free <= 1'b1;
      spd_mag_d <= 16'h0000;
    end else begin
      past_350  <= sel_350;
      past_free <= free_mode;
      spd_mag_d <= speed_mag;
    end
  end

  a_cmd_store: assert property (
    cmd_strobe |=> drive_command_word_three == $past(cmd_word_in))
    else $error("command word not stored");

  a_fsp_select: assert property (
    past_350 |-> ctrl.fixed_setpoint_sel == $past(drive_command_word_three[3:0]))
    else $error("fixed setpoint select wrong");

  a_mps_select: assert property (
    past_350 |-> ctrl.motor_parameter_set == $past(drive_command_word_three[5:4]))
    else $error("motor parameter set wrong");

  a_droop_mode: assert property (
    past_350 |-> ctrl.droop_enable == $past(drive_command_word_three[11]))
    else $error("droop enable wrong");

  a_torque_mode: assert property (
    past_350 |-> ctrl.torque_mode == $past(drive_command_word_three[12]))
    else $error("control mode wrong");

  a_ext_fault: assert property (
    (sel_350 && cmd_strobe && !cmd_word_in[13]) ##1 sel_350 |=> ctrl.ext_fault)
    else $error("external fault not raised");

  a_cps_bit: assert property (
    past_350 |-> ctrl.command_parameter_set_bit1 == $past(drive_command_word_three[15]))
    else $error("command set bit wrong");

  a_leave_clear: assert property (
    $fell(link_on) |=> ctrl == 12'h000)
    else $error("connections not cleared");

  a_standstill: assert property (
    !past_free |-> drive_state_word_three[1] == (spd_mag_d > $past(limits.standstill_thr)))
    else $error("standstill bit wrong");

  a_min_speed: assert property (
    !past_free |-> drive_state_word_three[2] == (spd_mag_d > $past(limits.min_speed)))
    else $error("minimum speed bit wrong");

  a_current_thr: assert property (
    !past_free |-> drive_state_word_three[3] ==
      ($past(meas.current_act) >= $past(limits.current_thr)))
    else $error("current bit wrong");

  a_speed_two: assert property (
    !past_free |-> drive_state_word_three[4] == (spd_mag_d > $past(limits.speed_thr2)))
    else $error("speed threshold bit wrong");

  a_speed_pair: assert property (
    !past_free |-> drive_state_word_three[5] != drive_state_word_three[4])
    else $error("speed bits not complementary");

  a_vdc_low: assert property (
    !past_free |-> drive_state_word_three[7] ==
      ($past(meas.dc_link) <= $past(limits.dc_link_thr)))
    else $error("low voltage bit wrong");

  a_vdc_pair: assert property (
    !past_free |-> drive_state_word_three[8] != drive_state_word_three[7])
    else $error("voltage bits not complementary");

  a_ramp_done: assert property (
    !past_free && $past(meas.ramp_active) |-> !drive_state_word_three[9])
    else $error("ramp bit wrong");

  a_tech_limits: assert property (
    !past_free |-> !(drive_state_word_three[10] && drive_state_word_three[11]) ||
      $past(limits.tech_upper) < $past(limits.tech_lower))
    else $error("controller limit bits clash");

  a_tech_high: assert property (
    !past_free |-> drive_state_word_three[11] ==
      ($signed($past(meas.tech_out)) > $signed($past(limits.tech_upper))))
    else $error("upper limit bit wrong");

  a_map_locked: assert property (
    map_wr && !free_mode |=> map_reject && $stable(cmd_map) && $stable(stat_map))
    else $error("locked connection changed");

  a_unused_zero: assert property (
    !past_free |-> drive_state_word_three[15:12] == 4'h0)
    else $error("unused status bits set");

  a_map_taken: assert property (
    map_wr && free_mode |=> map_accept && !map_reject)
    else $error("free connection write not accepted");

  a_accept_only: assert property (
    map_accept |-> $past(map_ok))
    else $error("accept without write");

  a_reject_only: assert property (
    map_reject |-> $past(map_wr) && !$past(free_mode))
    else $error("reject without locked write");

  a_answer_excl: assert property (
    !(map_accept && map_reject))
    else $error("accept and reject together");

  a_answer_pulse: assert property (
    map_accept && !map_ok |=> !map_accept)
    else $error("accept longer than one cycle");

  a_map_status: assert property (
    map_ok && map_is_status |=> stat_map[$past(map_idx)] == $past(map_src))
    else $error("status connection not written");

  a_map_cmd: assert property (
    map_ok && !map_is_status |=> cmd_map[$past(map_idx)] == $past(map_src))
    else $error("command connection not written");

  a_idle_table: assert property (
    !map_ok |=> $stable(cmd_map) && $stable(stat_map))
    else $error("connection changed without write");

  a_tech_en: assert property (
    past_350 |-> ctrl.tech_ctrl_enable == $past(drive_command_word_three[CMD_TECH_EN]))
    else $error("controller enable wrong");

  a_dcb_en: assert property (
    past_350 |-> ctrl.dc_brake_enable == $past(drive_command_word_three[CMD_DCB_EN]))
    else $error("brake enable wrong");

  a_dcb_status: assert property (
    !past_free |-> drive_state_word_three[ST_DCB_ACTIVE] == $past(meas.dc_brake_active))
    else $error("brake status bit wrong");

  a_sp_status: assert property (
    !past_free |-> drive_state_word_three[ST_SP_REACHED] == $past(meas.setpoint_reached))
    else $error("setpoint status bit wrong");

  a_free_cmd: assert property (
    $past(free_mode) |->
      ctrl.torque_mode == $past(drive_command_word_three[cmd_map[CMD_TORQUE]]))
    else $error("free command connection wrong");

  a_free_fault: assert property (
    $past(free_mode) |->
      ctrl.ext_fault == !$past(drive_command_word_three[cmd_map[CMD_NO_EXT_FAULT]]))
    else $error("free fault connection wrong");

  a_free_stat: assert property (
    $past(free_mode) |->
      drive_state_word_three[12] == $past(status_src[stat_map[12]]))
    else $error("free status connection wrong");

  a_free_standstill: assert property (
    $past(free_mode) && $past(stat_map[ST_STANDSTILL]) == 4'h1 |->
      drive_state_word_three[1] == (spd_mag_d > $past(limits.standstill_thr)))
    else $error("free standstill bit wrong");

  a_ext_clear: assert property (
    past_350 && $past(drive_command_word_three[CMD_NO_EXT_FAULT]) |-> !ctrl.ext_fault)
    else $error("external fault without cause");

  a_forced_zero: assert property (
    !link_on |=> ctrl == 12'h000)
    else $error("functions not forced off");

  a_tech_low: assert property (
    !past_free |-> drive_state_word_three[10] ==
      ($signed($past(meas.tech_out)) <= $signed($past(limits.tech_lower))))
    else $error("lower limit bit wrong");

  a_vdc_high: assert property (
    !past_free |-> drive_state_word_three[8] ==
      ($past(meas.dc_link) > $past(limits.dc_link_thr)))
    else $error("high voltage bit wrong");

  a_speed_below: assert property (
    !past_free |-> drive_state_word_three[5] == (spd_mag_d <= $past(limits.speed_thr2)))
    else $error("low speed bit wrong");

  a_ramp_idle: assert property (
    !past_free && !$past(meas.ramp_active) |-> drive_state_word_three[9])
    else $error("ramp done bit missing");

  a_cmd_hold: assert property (
    !cmd_strobe |=> $stable(drive_command_word_three))
    else $error("command word changed without strobe");

  c_leave_telegram: cover property ($fell(sel_350));
  c_map_accept: cover property (map_ok ##1 map_accept);
  c_ext_fault: cover property (sel_350 && ctrl.ext_fault);
  c_torque: cover property (sel_350 && ctrl.torque_mode);
  c_free_remap: cover property ($past(free_mode) && drive_state_word_three[12]);

endmodule // dcsw_top

//--- verif/dcsw_master.sv
`timescale 1ns/1ps
module dcsw_master (
  // Clock
  input  wire logic   sys_clk,
  // Command word to the drive
  output logic        cmd_strobe,
  output logic [15:0] cmd_word_in
);
  logic [15:0] last_word = 16'h2000;
  initial begin
    cmd_strobe = 1'b0;
    cmd_word_in = ~last_word;
  end
  // Word held across one rising edge
  task automatic send(input logic [15:0] w);
    cmd_strobe = 1'b1;
    cmd_word_in = w;
    last_word = w;
    @(negedge sys_clk);
  endtask
  // Released word shows the inverse
  task automatic idle();
    cmd_strobe = 1'b0;
    cmd_word_in = ~last_word;
    @(negedge sys_clk);
  endtask
endmodule // dcsw_master

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dcsw_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic [9:0]   telegram_sel = 10'h15e;
  logic         cmd_strobe;
  logic [15:0]  cmd_word_in;
  dcsw_meas_t   meas = '0;
  dcsw_limits_t limits = '0;
  logic         map_wr = 1'b0;
  logic         map_is_status = 1'b0;
  dcsw_sel_t    map_idx = '0;
  dcsw_sel_t    map_src = '0;
  logic [15:0]  cw3;
  logic [15:0]  sw3;
  dcsw_ctrl_t   ctrl;
  logic         map_accept;
  logic         map_reject;
  int           bad_count = 0;
  int           checked = 0;
  int           seed = 32'ha6dc;
  logic [15:0]  qw[$];
  logic [11:0]  qc[$];
  logic [15:0]  qs[$];
  logic [1:0]   pc = '0;
  logic         ps = 1'b0;
  logic         st_mark = 1'b0;
  logic [15:0]  w;

  always #4 sys_clk = ~sys_clk;

  dcsw_master i_dcsw_master (.sys_clk(sys_clk), .cmd_strobe(cmd_strobe),
    .cmd_word_in(cmd_word_in));
  dcsw_top i_dcsw_top (.sys_clk(sys_clk), .rst(rst), .telegram_sel(telegram_sel),
    .cmd_strobe(cmd_strobe), .cmd_word_in(cmd_word_in), .meas(meas), .limits(limits),
    .map_wr(map_wr), .map_is_status(map_is_status), .map_idx(map_idx), .map_src(map_src),
    .drive_command_word_three(cw3), .drive_state_word_three(sw3), .ctrl(ctrl),
    .map_accept(map_accept), .map_reject(map_reject));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [11:0] dec(input logic [15:0] v);
    return {v[3:0], v[5:4], v[8], v[9], v[11], v[12], ~v[13], v[15]};
  endfunction

  function automatic logic [15:0] stat(input dcsw_meas_t m, input dcsw_limits_t l);
    int n;
    n = m.speed_act[15] ? -int'(m.speed_act) : int'(m.speed_act);
    return {4'h0, m.tech_out > l.tech_upper, m.tech_out <= l.tech_lower, ~m.ramp_active,
            m.dc_link > l.dc_link_thr, m.dc_link <= l.dc_link_thr, m.setpoint_reached,
            n <= int'(l.speed_thr2), n > int'(l.speed_thr2), m.current_act >= l.current_thr,
            n > int'(l.min_speed), n > int'(l.standstill_thr), m.dc_brake_active};
  endfunction

  // Monitor: pops the oldest note as each result appears
  always @(posedge sys_clk) begin
    pc <= {pc[0], cmd_strobe};
    ps <= st_mark;
  end
  always @(negedge sys_clk) begin
    if (pc[0] && qw.size() > 0) check(cw3, qw.pop_front(), "cmd word");
    if (pc[1] && qc.size() > 0)
      check({4'h0, ctrl}, {4'h0, qc.pop_front()}, "ctrl");
    if (ps && qs.size() > 0)
      check(sw3, qs.pop_front(), "status");
  end

  task automatic cmd(input logic [15:0] v, input logic [11:0] e);
    qw.push_back(v);
    qc.push_back(e);
    i_dcsw_master.send(v);
  endtask

  task automatic map(input logic st, input logic [3:0] idx, input logic [3:0] src,
                     input logic [1:0] e);
    map_wr = 1'b1;
    map_is_status = st;
    map_idx = idx;
    map_src = src;
    @(negedge sys_clk);
    map_wr = 1'b0;
    check({14'h0, map_accept, map_reject}, {14'h0, e}, "map answer");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("CHECK FAILED t=%0t timeout", $time);
    finish_test();
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    check(cw3, 16'h2000, "reset word");
    check(sw3, 16'h0000, "reset status");
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      w = 16'($random(seed));
      w[5:0] = {i[1:0], i[3:0]};
      cmd(w, dec(w));
    end
    i_dcsw_master.idle();
    $display("test command decode done");
    st_mark = 1'b1;
    for (int i = 0; i < 24; i++) begin
      meas = 67'({$random(seed), $random(seed), $random(seed)});
      limits = 112'({$random(seed), $random(seed), $random(seed), $random(seed)});
      if (i[0]) begin
        limits.speed_thr2 = 16'(meas.speed_act[15] ? -meas.speed_act : meas.speed_act);
        limits.standstill_thr = limits.speed_thr2;
        limits.min_speed = limits.speed_thr2;
        limits.current_thr = meas.current_act;
        limits.dc_link_thr = meas.dc_link;
        limits.tech_lower = meas.tech_out;
        limits.tech_upper = meas.tech_out;
      end
      qs.push_back(stat(meas, limits));
      @(negedge sys_clk);
    end
    st_mark = 1'b0;
    @(negedge sys_clk);
    $display("test status word done");
    map(1'b0, 4'hc, 4'h0, 2'b01);
    w = 16'h1000;
    cmd(w, dec(w));
    i_dcsw_master.idle();
    telegram_sel = 10'h001;
    cmd(16'hffff, 12'h000);
    i_dcsw_master.idle();
    map(1'b1, 4'hc, 4'h3, 2'b01);
    i_dcsw_master.idle();
    $display("test telegram change done");
    telegram_sel = 10'h3e7;
    map(1'b0, 4'hc, 4'h0, 2'b10);
    w = 16'h2001;
    cmd(w, dec(16'h3001));
    i_dcsw_master.idle();
    map(1'b1, 4'hc, 4'h3, 2'b10);
    meas.current_act = 16'h0100;
    limits.current_thr = 16'h0100;
    qs.push_back(stat(meas, limits) | 16'h1000);
    st_mark = 1'b1;
    @(negedge sys_clk);
    st_mark = 1'b0;
    $display("test free configuration done");
    for (int i = 0; i < 10 && (qw.size() + qc.size() + qs.size()) > 0; i++)
      @(negedge sys_clk);
    if ((qw.size() + qc.size() + qs.size()) > 0) begin
      bad_count++;
      $display("CHECK FAILED t=%0t results missing", $time);
    end
    finish_test();
  end
endmodule // tb_top
